// *** verilog/hbsp_pkg.sv ***
// Purpose: Constants and types for the half-bridge serial command port
// Assumes: 16-bit frames, MSB first, shift clock sampled by clk
// Notes:   Fault inputs come from the protection logic around the port
// How it works
// - Port answers only while enable high
// - Raising enable leaves reset, accepts commands
// - Dropping enable clears all, drivers off
// - Each frame swaps its bits full duplex, word in last sixteen
// - Prefix thermal bit driven after select falls
// - Input bits sampled MSB first, clear first
// - Status shifted out MSB first on rises
// - Select rising ends frame, output released
// - Load word only without frame error
// - Clear bit clears faults of group
// - Bit fourteen picks bridges 8-7 or 6-1
// - Group one field layout for bridges 8-7
// - Group zero field layout for bridges 6-1
// - Command bits zero after power-on reset
// - Frame error unless 16 plus multiple eight
// - Status bits zero after power-on reset
// - Config status zero when bridge disabled
package hbsp_pkg;

    // ------------------------------------------------------------
    // Frame and field layout
    // ------------------------------------------------------------
    localparam int          FRAME_BITS   = 16;
    localparam int          BRIDGES      = 8;
    localparam int          POS_CLEAR    = 15;
    localparam int          POS_GROUP    = 14;
    localparam int          POS_ULD      = 13;
    localparam int          POS_EN_LO    = 7;
    localparam int          POS_CFG_LO   = 1;
    localparam int          POS_OV_LOCK  = 0;
    localparam int          POS_OCS      = 15;
    localparam int          POS_PSF      = 14;
    localparam int          POS_ULDS     = 13;
    localparam int          POS_TW       = 0;
    localparam logic [15:0] CMD_RESET    = 16'h0000;
    localparam logic [15:0] STAT_RESET   = 16'h0000;
    localparam logic [7:0]  BRIDGE_RESET = 8'h00;
    localparam logic [15:0] HI_EN_MASK   = 16'h0180;
    localparam logic [15:0] HI_CFG_MASK  = 16'h0006;
    localparam logic [15:0] LO_EN_MASK   = 16'h1F80;
    localparam logic [15:0] LO_CFG_MASK  = 16'h007E;

    // Bit counter: 16 for the first word, then modulo 8
    localparam logic [4:0]  CNT_FIRST    = 5'h10;
    localparam logic [4:0]  CNT_WRAP     = 5'h18;

    // Bridge control set derived from accepted commands
    typedef struct packed {
        logic [7:0] enable;
        logic [7:0] config_hs;
        logic       uld_hi;
        logic       uld_lo;
        logic       ov_lock;
    } hbsp_ctrl_t;

    // Fault inputs from the protection circuits
    typedef struct packed {
        logic       tsd;
        logic       tw;
        logic       psf;
        logic [7:0] ocs;
        logic [7:0] uld;
    } hbsp_fault_t;

    // Frame sampling state
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FRAME = 2'b01,
        ST_DONE  = 2'b10
    } hbsp_state_t;

endpackage : hbsp_pkg

// *** verilog/hbsp_sync.sv ***
// Purpose: Two flip-flop synchroniser for one pin
// Assumes: Reset value given per instance
// Notes:   First stage read only by the second
`timescale 1ns/1ns
`default_nettype none
module hbsp_sync #(
    parameter logic INIT = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output var  logic q
);
    logic meta;

    // Two stage resynchronisation
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= INIT;
            q    <= INIT;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : hbsp_sync
`default_nettype wire

// *** verilog/hbsp_fault_latch.sv ***
// Purpose: Latched bridge faults with group-wise clear
// Assumes: Fault inputs already on clk
// Notes:   A fault present while clearing stays set
`timescale 1ns/1ns
`default_nettype none
module hbsp_fault_latch
    import hbsp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sleep,
    input  wire logic [7:0] ocs_in,
    input  wire logic [7:0] uld_in,
    input  wire logic       tsd_in,
    input  wire logic [7:0] clear_mask,
    input  wire logic       clear_tsd,
    output var  logic [7:0] ocs_lat,
    output var  logic [7:0] uld_lat,
    output var  logic       tsd_lat
);
    // group fault clear; set wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ocs_lat <= BRIDGE_RESET;
            uld_lat <= BRIDGE_RESET;
            tsd_lat <= 1'b0;
        end else if (sleep) begin
            ocs_lat <= BRIDGE_RESET;
            uld_lat <= BRIDGE_RESET;
            tsd_lat <= 1'b0;
        end else begin
            ocs_lat <= (ocs_lat & ~clear_mask) | ocs_in;
            uld_lat <= (uld_lat & ~clear_mask) | uld_in;
            tsd_lat <= (tsd_lat & ~clear_tsd) | tsd_in;
        end
    end
endmodule : hbsp_fault_latch
`default_nettype wire

// *** verilog/hbsp_port.sv ***
// Purpose: Serial command and status port of an eight-bridge driver
// Assumes: Shift clock well below clk/4; pins synchronised here
// Notes:   Drivers are outputs of accepted commands and faults
`timescale 1ns/1ns
`default_nettype none
module hbsp_port
    import hbsp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        enable,
    input  wire logic        frame_select_n,
    input  wire logic        shift_clock,
    input  wire logic        serial_in,
    input  wire hbsp_fault_t fault_in,
    output var  logic        serial_out,
    output var  logic        serial_out_oe,
    output var  logic [7:0]  bridge_output_state,
    output var  logic [7:0]  bridge_config_state,
    output var  logic        underload_shutoff_en_hi,
    output var  logic        underload_shutoff_en_lo,
    output var  logic        overvoltage_lockout_en,
    output var  logic        sleep_mode
);
    // ------------------------------------------------------------
    // Reset and pin synchronisation
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_sync_n;
    logic en_s;
    logic sel_n_s;
    logic sck_s;
    logic sdi_s;
    logic sel_n_d;
    logic sck_d;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    hbsp_sync #(.INIT(1'b0)) u_sync_en (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .d     (enable),
        .q     (en_s)
    );
    hbsp_sync #(.INIT(1'b1)) u_sync_sel (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .d     (frame_select_n),
        .q     (sel_n_s)
    );
    hbsp_sync #(.INIT(1'b0)) u_sync_sck (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .d     (shift_clock),
        .q     (sck_s)
    );
    hbsp_sync #(.INIT(1'b0)) u_sync_sdi (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .d     (serial_in),
        .q     (sdi_s)
    );

    // Edge detection history
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sel_n_d <= 1'b1;
            sck_d   <= 1'b0;
        end else begin
            sel_n_d <= sel_n_s;
            sck_d   <= sck_s;
        end
    end

    logic sleep;
    logic sel_fall;
    logic sel_rise;
    logic sck_rise;
    logic sck_fall;
    assign sleep    = !en_s;
    assign sel_fall = en_s && sel_n_d && !sel_n_s;
    assign sel_rise = en_s && !sel_n_d && sel_n_s;
    assign sck_rise = en_s && !sel_n_s && !sck_d && sck_s;
    assign sck_fall = en_s && !sel_n_s && sck_d && !sck_s;

    // ------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------
    hbsp_state_t state;
    logic [15:0] rx_shift;
    logic [15:0] tx_shift;
    logic [4:0]  bit_cnt;
    logic        first_done;
    logic        frame_ok;
    logic        accept;
    logic [15:0] bridge_command_word;
    logic        last_group;
    logic [15:0] status_word;

    // valid length is 16, then multiples of 8
    assign frame_ok = first_done && (bit_cnt == CNT_FIRST);
    // accept only a frame without error
    assign accept   = (state == ST_FRAME) && sel_rise && frame_ok;

    // leave sleep once enable is seen high
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= ST_IDLE;
        end else if (sleep) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE:  if (sel_fall) state <= ST_FRAME;
                ST_FRAME: if (sel_rise) state <= ST_DONE;
                ST_DONE:  state <= ST_IDLE;
                default:  state <= ST_IDLE;
            endcase
        end
    end

    // sample input on falling shift edge, MSB first
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rx_shift <= CMD_RESET;
        end else if (sleep || sel_fall) begin
            rx_shift <= CMD_RESET;
        end else if (state == ST_FRAME && sck_fall) begin
            rx_shift <= {rx_shift[14:0], sdi_s};
        end
    end

    // modulo 16 first word, modulo 8 after
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bit_cnt    <= 5'h00;
            first_done <= 1'b0;
        end else if (sleep || sel_fall) begin
            bit_cnt    <= 5'h00;
            first_done <= 1'b0;
        end else if (state == ST_FRAME && sck_fall) begin
            if (bit_cnt == CNT_FIRST - 5'h01) begin
                first_done <= 1'b1;
                bit_cnt    <= CNT_FIRST;
            end else if (bit_cnt == CNT_WRAP - 5'h01) begin
                bit_cnt    <= CNT_FIRST;
            end else begin
                bit_cnt    <= bit_cnt + 5'h01;
            end
        end
    end

    // status out MSB first on each rising edge
    // prefix bit shown from select fall to first rise
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tx_shift   <= STAT_RESET;
            serial_out <= 1'b0;
        end else if (sleep) begin
            tx_shift   <= STAT_RESET;
            serial_out <= 1'b0;
        end else if (sel_fall) begin
            tx_shift   <= status_word;
            serial_out <= tsd_lat;
        end else if (state == ST_FRAME && sck_rise) begin
            serial_out <= tx_shift[15];
            // full duplex; daisy data follows status
            tx_shift   <= {tx_shift[14:0], sdi_s};
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            serial_out_oe <= 1'b0;
        end else begin
            serial_out_oe <= en_s && !sel_n_s;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bridge_command_word <= CMD_RESET;
        end else if (sleep) begin
            bridge_command_word <= CMD_RESET;
        end else if (accept) begin
            bridge_command_word <= rx_shift;
        end
    end

    // status group follows the last accepted word
    assign last_group = bridge_command_word[POS_GROUP];

    // ------------------------------------------------------------
    // Command decode and bridge control
    // ------------------------------------------------------------
    logic       grp_hi;
    logic [7:0] clear_mask;
    logic [7:0] ocs_lat;
    logic [7:0] uld_lat;
    logic       tsd_lat;
    hbsp_ctrl_t ctrl;
    logic [7:0] ocs_now;
    logic [7:0] grp_bits;
    logic [7:0] next_out;
    logic [7:0] uld_kill;

    // group select picks the bridge set
    assign grp_hi   = rx_shift[POS_GROUP];
    assign grp_bits = grp_hi ? 8'hC0 : 8'h3F;
    assign clear_mask = (accept && rx_shift[POS_CLEAR]) ? grp_bits : 8'h00;

    hbsp_fault_latch u_faults (
        .clk        (clk),
        .rst_n      (rst_sync_n),
        .sleep      (sleep),
        .ocs_in     (fault_in.ocs),
        .uld_in     (fault_in.uld),
        .tsd_in     (fault_in.tsd),
        .clear_mask (clear_mask),
        .clear_tsd  (accept && rx_shift[POS_CLEAR]),
        .ocs_lat    (ocs_lat),
        .uld_lat    (uld_lat),
        .tsd_lat    (tsd_lat)
    );

    // latched or live overcurrent turns a bridge output off
    assign ocs_now = ocs_lat | fault_in.ocs;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl <= '0;
        end else if (sleep) begin
            ctrl <= '0;
        end else if (accept) begin
            ctrl.ov_lock <= rx_shift[POS_OV_LOCK];
            if (grp_hi) begin
                ctrl.uld_hi         <= rx_shift[POS_ULD];
                ctrl.enable[7:6]    <= rx_shift[8:7];
                ctrl.config_hs[7:6] <= rx_shift[2:1];
            end else begin
                ctrl.uld_lo         <= rx_shift[POS_ULD];
                ctrl.enable[5:0]    <= rx_shift[12:7];
                ctrl.config_hs[5:0] <= rx_shift[6:1];
            end
        end
    end

    // outputs off on sleep; config zero when off
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bridge_output_state     <= BRIDGE_RESET;
            bridge_config_state     <= BRIDGE_RESET;
            underload_shutoff_en_hi <= 1'b0;
            underload_shutoff_en_lo <= 1'b0;
            overvoltage_lockout_en  <= 1'b0;
            sleep_mode              <= 1'b1;
        end else begin
            bridge_output_state     <= sleep ? BRIDGE_RESET : next_out;
            bridge_config_state     <= sleep ? BRIDGE_RESET : (next_out & ctrl.config_hs);
            underload_shutoff_en_hi <= !sleep && ctrl.uld_hi;
            underload_shutoff_en_lo <= !sleep && ctrl.uld_lo;
            overvoltage_lockout_en  <= !sleep && ctrl.ov_lock;
            sleep_mode              <= sleep;
        end
    end

    // bridge drive from command, latched faults and live overcurrent and supply fault
    assign uld_kill = uld_lat & {{2{ctrl.uld_hi}}, {6{ctrl.uld_lo}}};
    assign next_out = ctrl.enable & ~ocs_now & ~uld_kill
                    & {8{!(tsd_lat || (fault_in.psf && ctrl.ov_lock))}};

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    // status built from cleared state; by last group
    always_comb begin
        status_word           = STAT_RESET;
        status_word[POS_PSF]  = fault_in.psf;
        status_word[POS_TW]   = fault_in.tw;
        if (last_group) begin
            status_word[POS_OCS]  = |ocs_lat[7:6];
            status_word[POS_ULDS] = |uld_lat[7:6];
            status_word[8:7]      = bridge_output_state[7:6];
            status_word[2:1]      = bridge_config_state[7:6];
        end else begin
            status_word[POS_OCS]  = |ocs_lat[5:0];
            status_word[POS_ULDS] = |uld_lat[5:0];
            status_word[12:7]     = bridge_output_state[5:0];
            status_word[6:1]      = bridge_config_state[5:0];
        end
    end
endmodule : hbsp_port
`default_nettype wire

// *** verif/hbsp_port_checker.sv ***
// Purpose: Port-level assertions for the serial command port
// Assumes: Host idles its pins at their bias levels between frames
// Notes:   Bound onto hbsp_port from the bench top
`timescale 1ns/1ns
`default_nettype none
module hbsp_port_checker
    import hbsp_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        enable,
    input wire logic        frame_select_n,
    input wire logic        shift_clock,
    input wire logic        serial_in,
    input wire hbsp_fault_t fault_in,
    input wire logic        serial_out,
    input wire logic        serial_out_oe,
    input wire logic [7:0]  bridge_output_state,
    input wire logic [7:0]  bridge_config_state,
    input wire logic        underload_shutoff_en_hi,
    input wire logic        underload_shutoff_en_lo,
    input wire logic        overvoltage_lockout_en,
    input wire logic        sleep_mode
);
    // ----------------------------------------------------------------
    // Assertions, all on the system clock
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_sleep;
        !enable [*5] |-> sleep_mode && bridge_output_state == 8'h00
            && !overvoltage_lockout_en && !underload_shutoff_en_lo;
    endproperty
    a_sleep: assert property (p_sleep) else $error("state kept while asleep");
    property p_wake; $rose(enable) |-> ##[2:6] !sleep_mode; endproperty
    a_wake: assert property (p_wake) else $error("no wake after enable");
    property p_idle; !enable [*5] |-> !serial_out_oe; endproperty
    a_idle: assert property (p_idle) else $error("output driven while disabled");
    property p_cfg; (bridge_config_state & ~bridge_output_state) == 8'h00; endproperty
    a_cfg: assert property (p_cfg) else $error("config set on disabled bridge");
    property p_prefix;
        enable [*8] ##1 $fell(frame_select_n) |-> ##[1:5] serial_out_oe;
    endproperty
    a_prefix: assert property (p_prefix) else $error("output not driven after select");
    property p_release; $rose(frame_select_n) |-> ##[1:5] !serial_out_oe; endproperty
    a_release: assert property (p_release) else $error("output not released");
    property p_por;
        $rose(rst_n) |-> bridge_output_state == 8'h00 && bridge_config_state == 8'h00
            && !overvoltage_lockout_en;
    endproperty
    a_por: assert property (p_por) else $error("outputs not zero after reset");
    property p_load;
        $rose(overvoltage_lockout_en) |-> $past(frame_select_n) && $past(frame_select_n, 3);
    endproperty
    a_load: assert property (p_load) else $error("word applied inside a frame");
endmodule : hbsp_port_checker
`default_nettype wire

// *** verif/hbsp_host.sv ***
// Purpose: Host model driving frames on the serial pins
// Assumes: Shift clock timed in ns, free of the system clock phase
// Notes:   Fill ones lead the word when more than sixteen bits go out
`timescale 1ns/1ns
`default_nettype none
module hbsp_host (
    output var  logic frame_select_n,
    output var  logic shift_clock,
    input  wire logic serial_out,
    output var  logic serial_in
);
    initial begin
        frame_select_n = 1'b1;
        shift_clock    = 1'b0;
        serial_in      = 1'b0;
    end

    // one frame; rx holds prefix then status, sampled before rises
    task automatic frame(input logic [15:0] word, input int nbits, input int half,
                         output logic [16:0] rx);
        int k;
        rx = 17'h0_0000;
        #13;
        frame_select_n = 1'b0;
        #(half);
        for (k = 0; k < nbits; k++) begin
            #(half);
            if (k < 17)
                rx[16 - k] = serial_out;
            shift_clock = 1'b1;
            serial_in   = (k < nbits - 16) ? 1'b1 : word[nbits - 1 - k];
            #(half);
            shift_clock = 1'b0;
        end
        #(half);
        if (nbits < 17)
            rx[16 - nbits] = serial_out;
        serial_in      = 1'b0;
        frame_select_n = 1'b1;
        #1000;
    endtask : frame
endmodule : hbsp_host
`default_nettype wire

// *** verif/half_bridge_spi_command_port_tb.sv ***
// Purpose: Self-checking bench for the serial command port
// Assumes: Host model owns the serial pins, bench owns enable and faults
// Notes:   Bridge outputs checked once each accepted word has landed
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module half_bridge_spi_command_port_tb;
    import hbsp_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        enable = 1'b0;
    hbsp_fault_t fault_in = '0;
    logic        frame_select_n, shift_clock, serial_in, serial_out, serial_out_oe;
    logic [7:0]  bridge_output_state, bridge_config_state;
    logic        underload_shutoff_en_hi, underload_shutoff_en_lo;
    logic        overvoltage_lockout_en, sleep_mode;
    logic [16:0] rx;
    int          error_cnt = 0;
    int          checked = 0;
    // Released output shows the inverse so a late sample is caught
    wire         so_pin = serial_out_oe ? serial_out : ~serial_out;

    always #50 clk = ~clk;

    hbsp_port u_dut (.clk(clk), .rst_n(rst_n), .enable(enable), .fault_in(fault_in),
        .frame_select_n(frame_select_n), .shift_clock(shift_clock), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .bridge_output_state(bridge_output_state), .bridge_config_state(bridge_config_state),
        .underload_shutoff_en_hi(underload_shutoff_en_hi),
        .underload_shutoff_en_lo(underload_shutoff_en_lo),
        .overvoltage_lockout_en(overvoltage_lockout_en), .sleep_mode(sleep_mode));
    hbsp_host u_host (.frame_select_n(frame_select_n), .shift_clock(shift_clock),
        .serial_out(so_pin), .serial_in(serial_in));

    // Verdict and end of run
    task automatic close_out;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    task automatic wait_awake;
        int n;
        for (n = 0; n < 20 && sleep_mode !== 1'b0; n++)
            @(posedge clk);
        if (sleep_mode !== 1'b0) begin
            error_cnt++;
            close_out();
        end
        repeat (6) @(posedge clk);
    endtask : wait_awake

    task automatic t_lo;
        u_host.frame(16'h3FAB, 16, 400, rx);
        `CHK("status", 17'h0_0000, rx)
        `CHK("state", 8'h3F, bridge_output_state)
        `CHK("config", 8'h15, bridge_config_state)
        `CHK("uld lo", 1'b1, underload_shutoff_en_lo)
        `CHK("ov lockout", 1'b1, overvoltage_lockout_en)
    endtask : t_lo

    task automatic t_hi;
        u_host.frame(16'h6184, 16, 400, rx);
        `CHK("status", 17'h0_1FAA, rx)
        `CHK("state", 8'hFF, bridge_output_state)
        `CHK("config", 8'h95, bridge_config_state)
        `CHK("uld hi", 1'b1, underload_shutoff_en_hi)
        `CHK("ov lockout", 1'b0, overvoltage_lockout_en)
    endtask : t_hi

    task automatic t_count;
        u_host.frame(16'h4000, 15, 400, rx);
        `CHK("status", 17'h0_0184, rx)
        `CHK("state", 8'hFF, bridge_output_state)
        u_host.frame(16'h4080, 24, 400, rx);
        `CHK("status", 17'h0_0184, rx)
        `CHK("state", 8'h7F, bridge_output_state)
        `CHK("config", 8'h15, bridge_config_state)
    endtask : t_count

    task automatic t_fault;
        @(posedge clk);
        fault_in.tsd <= 1'b1;
        fault_in.ocs <= 8'h01;
        repeat (4) @(posedge clk);
        fault_in.tsd <= 1'b0;
        fault_in.ocs <= 8'h00;
        repeat (4) @(posedge clk);
        `CHK("bridge1", 1'b0, bridge_output_state[0])
        `CHK("config1", 1'b0, bridge_config_state[0])
        u_host.frame(16'h9FAA, 16, 400, rx);
        `CHK("prefix", 2'b10, rx[16:15])
        `CHK("group lo", 6'h3F, bridge_output_state[5:0])
        u_host.frame(16'h1FAA, 16, 400, rx);
        `CHK("status", 17'h0_1FAA, rx)
        // Supply fault and warning show in status, no lockout
        @(posedge clk);
        fault_in.psf <= 1'b1;
        fault_in.tw  <= 1'b1;
        repeat (4) @(posedge clk);
        u_host.frame(16'h1FAA, 16, 400, rx);
        @(posedge clk);
        fault_in.psf <= 1'b0;
        fault_in.tw  <= 1'b0;
        `CHK("status", 17'h0_5FAB, rx)
        `CHK("state", 8'h7F, bridge_output_state)
    endtask : t_fault

    task automatic t_sleep;
        @(posedge clk);
        enable <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK("state", 8'h00, bridge_output_state)
        `CHK("sleep", 1'b1, sleep_mode)
        u_host.frame(16'h3FAB, 16, 400, rx);
        `CHK("ov lockout", 1'b0, overvoltage_lockout_en)
        @(posedge clk);
        enable <= 1'b1;
        wait_awake();
        `CHK("uld hi", 1'b0, underload_shutoff_en_hi)
        `CHK("state", 8'h00, bridge_output_state)
        u_host.frame(16'h0000, 16, 400, rx);
        `CHK("status", 17'h0_0000, rx)
    endtask : t_sleep

    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("state", 8'h00, bridge_output_state)
        `CHK("sleep", 1'b1, sleep_mode)
        enable <= 1'b1;
        wait_awake();
        t_lo();
        t_hi();
        t_count();
        t_fault();
        t_sleep();
        close_out();
    end
endmodule : half_bridge_spi_command_port_tb

bind hbsp_port hbsp_port_checker u_chk (.clk(clk), .rst_n(rst_n), .enable(enable),
    .frame_select_n(frame_select_n), .shift_clock(shift_clock), .serial_in(serial_in),
    .fault_in(fault_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .bridge_output_state(bridge_output_state), .bridge_config_state(bridge_config_state),
    .underload_shutoff_en_hi(underload_shutoff_en_hi),
    .underload_shutoff_en_lo(underload_shutoff_en_lo),
    .overvoltage_lockout_en(overvoltage_lockout_en), .sleep_mode(sleep_mode));
`default_nettype wire
